/* File: aosrch_drive_model.sv */
/*
  Drive model: integrates the velocity command into an encoder count,
  gives an index marker and one home switch at a fixed distance.
  Assumes it sees the home selector value that software last wrote.
*/
`timescale 1ns/1ps
module aosrch_drive_model #(
  parameter int DIV = 4,
  parameter int HOME_EDGE = 3000
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [7:0] i_sel,
  input wire logic signed [31:0] i_vel,
  output logic signed [31:0] o_enc_pos,
  output logic o_index,
  output logic [15:0] o_unit_in,
  output logic [15:0] o_drv_in
);
  int cnt;
  logic home_n;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt <= 0;
      o_enc_pos <= '0;
    end else begin
      cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
      if (cnt == DIV - 1) begin
        o_enc_pos <= o_enc_pos + i_vel;
      end
    end
  end
  // Half duty marker so both travel directions meet a rising edge
  assign o_index = o_enc_pos[10];
  assign home_n = !(o_enc_pos >= HOME_EDGE || o_enc_pos <= -HOME_EDGE);
  // Only the selected input carries the switch, so a wrong pick never homes
  always_comb begin
    o_unit_in = '1;
    o_drv_in = '1;
    if (i_sel < 8'h10) begin
      o_unit_in[i_sel[3:0]] = home_n;
    end else if (i_sel < 8'h20) begin
      o_drv_in[i_sel[3:0]] = home_n;
    end
  end
endmodule

/* File: aosrch_home_sel.sv */
/*
  Home switch selector: picks one of 32 inputs, 16 shared unit inputs and
  16 drive inputs of this axis, and reports the switch as asserted when low.
  Assumes inputs are synchronous to the clock.
*/
`timescale 1ns/1ps
module aosrch_home_sel #(
  parameter int N = aosrch_pkg::IN_N
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [aosrch_pkg::SEL_W-1:0] sel,
  input wire logic [N-1:0] unit_in,
  input wire logic [N-1:0] drv_in,
  output logic home_active
);
  logic home_next;

  // Low half selects the shared inputs, high half the drive inputs
  function automatic logic pick(input logic [aosrch_pkg::SEL_W-1:0] s,
                                input logic [2*N-1:0] all_in);
    pick = all_in[s];
  endfunction

  always_comb begin
    home_next = ~pick(sel, {drv_in, unit_in});
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      home_active <= 1'b0;
    end else begin
      home_active <= home_next;
    end
  end

  chk_home_low_level: assert property (@(posedge clk) disable iff (!arst_n)
    home_active == ~$past(pick(sel, {drv_in, unit_in})))
    else $error("home switch not active-low");
endmodule

/* File: aosrch_pkg.sv */
/*
  Shared constants and types for the axis origin search block: register
  offsets, reset values, error flag positions, sequence codes and timing.
  Assumes one 200 MHz clock and a servo update derived from it by a divider.
*/
package aosrch_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int POS_W = 32;
  localparam int SEL_W = 5;
  localparam int IN_N = 16;
  localparam int ERR_W = 12;
  localparam int IRQ_W = 3;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] REG_SEQ = 8'h00;
  localparam logic [ADDR_W-1:0] REG_HOME_SEL = 8'h04;
  localparam logic [ADDR_W-1:0] REG_CREEP = 8'h08;
  localparam logic [ADDR_W-1:0] REG_SPEED = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_RAMP = 8'h10;
  localparam logic [ADDR_W-1:0] REG_FE_BOUND = 8'h14;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] REG_DEMAND = 8'h1c;
  localparam logic [ADDR_W-1:0] REG_MEASURED = 8'h20;
  localparam logic [ADDR_W-1:0] REG_ERR_FLAGS = 8'h24;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h28;
  localparam logic [ADDR_W-1:0] REG_IRQ_CLR = 8'h2c;
  localparam logic [ADDR_W-1:0] REG_IRQ_EN = 8'h30;

  // Reset values
  localparam logic [DATA_W-1:0] CREEP_RST = 32'h0000_0010;
  localparam logic [DATA_W-1:0] SPEED_RST = 32'h0000_0100;
  localparam logic [DATA_W-1:0] RAMP_RST = 32'h0000_0004;
  localparam logic [DATA_W-1:0] FE_BOUND_RST = 32'h0000_1000;
  localparam logic [7:0] SEL_RST = 8'h00;

  // Sequence codes and selector range
  localparam logic [7:0] SEQ_CLEAR = 8'h00;
  localparam logic [7:0] SEQ_Z_FWD = 8'h01;
  localparam logic [7:0] SEQ_Z_REV = 8'h02;
  localparam logic [7:0] SEQ_SW_FWD = 8'h03;
  localparam logic [7:0] SEQ_SW_REV = 8'h04;
  localparam logic [7:0] SEQ_SWZ_FWD = 8'h05;
  localparam logic [7:0] SEQ_SWZ_REV = 8'h06;
  localparam logic [7:0] SEQ_MAX = SEQ_SWZ_REV;
  localparam logic [7:0] SEL_MAX = 8'h1f;

  // Axis error flag positions
  localparam int ERR_FE_WARN = 1;
  localparam int ERR_COMMS = 2;
  localparam int ERR_DRIVE = 3;
  localparam int ERR_FOLLOWING_ERROR_BOUND = 8;
  localparam int ERR_CANCEL = 11;
  localparam logic [ERR_W-1:0] ERR_CLEAR_MASK = 12'h90e;

  // Interrupt status positions
  localparam int IRQ_DONE = 0;
  localparam int IRQ_REJECT = 1;
  localparam int IRQ_CANCEL = 2;

  // Servo update period
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SERVO_PERIOD_NS = 1000;
  localparam int SERVO_DIV = (SERVO_PERIOD_NS * 1000) / CLK_PERIOD_PS;

  typedef enum {ST_IDLE, ST_FAST, ST_CREEP_OFF, ST_CREEP_Z, ST_ZERO, ST_STOP} aosrch_state_t;

  typedef struct packed {
    logic feedhold_n;
    logic fwd_jog_n;
    logic rev_jog_n;
    logic fwd_lim_n;
    logic rev_lim_n;
  } aosrch_sw_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } aosrch_bus_t;
endpackage

/* File: aosrch_ramp.sv */
/*
  Velocity ramp: on each servo update the velocity steps toward the target
  by at most the ramp rate. Assumes a one-cycle update enable.
*/
`timescale 1ns/1ps
module aosrch_ramp #(
  parameter int W = aosrch_pkg::POS_W
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic tick,
  input wire logic signed [W-1:0] target,
  input wire logic signed [W-1:0] rate,
  output logic signed [W-1:0] vel
);
  logic signed [W-1:0] vel_next;

  function automatic logic signed [W-1:0] step_to(input logic signed [W-1:0] cur,
                                                  input logic signed [W-1:0] tgt,
                                                  input logic signed [W-1:0] stp);
    if (cur < tgt) begin
      step_to = (tgt - cur > stp) ? cur + stp : tgt;
    end else begin
      step_to = (cur - tgt > stp) ? cur - stp : tgt;
    end
  endfunction

  always_comb begin
    vel_next = tick ? step_to(vel, target, rate) : vel;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      vel <= '0;
    end else begin
      vel <= vel_next;
    end
  end

  chk_ramp_on_tick: assert property (@(posedge clk) disable iff (!arst_n)
    !$past(tick) |-> $stable(vel))
    else $error("velocity changed between updates");
endmodule

/* File: aosrch_top.sv */
/*
  Origin search sequencer for one axis: six search sequences plus an error
  clear, demand position integration, error flags and a level interrupt.
  Assumes a plain register port, synchronous switch and index inputs, and
  an encoder count that the drive supplies each cycle.
*/
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module aosrch_top #(
  parameter int SERVO_DIV = aosrch_pkg::SERVO_DIV
) (
  input wire logic I_CLOCK,
  input wire logic I_ARST_N,
  input wire aosrch_pkg::aosrch_bus_t I_BUS,
  input wire aosrch_pkg::aosrch_sw_t I_SWITCHES_N,
  input wire logic [aosrch_pkg::IN_N-1:0] I_UNIT_IN,
  input wire logic [aosrch_pkg::IN_N-1:0] I_DRV_IN,
  input wire logic [aosrch_pkg::POS_W-1:0] I_ENC_POS,
  input wire logic I_ENC_INDEX,
  input wire logic I_DRV_COMMS_ERR,
  input wire logic I_DRV_FAULT,
  output logic [aosrch_pkg::DATA_W-1:0] O_RDATA,
  output logic O_IRQ,
  output logic O_BUSY,
  output logic signed [aosrch_pkg::POS_W-1:0] O_VEL_CMD,
  output logic signed [aosrch_pkg::POS_W-1:0] O_DEMAND_POS
);
  localparam int PW = aosrch_pkg::POS_W;
  localparam int DW = aosrch_pkg::DATA_W;
  localparam int EW = aosrch_pkg::ERR_W;
  localparam int IW = aosrch_pkg::IRQ_W;
  localparam logic [15:0] DIV_LAST = 16'(SERVO_DIV - 1);

  aosrch_pkg::aosrch_state_t state_reg, state_next;
  logic [7:0] seq_reg, seq_next, sel_reg, sel_next;
  logic dir_fwd_reg, dir_fwd_next;
  logic [DW-1:0] creep_reg, creep_next, speed_reg, speed_next;
  logic [DW-1:0] ramp_reg, ramp_next, bound_reg, bound_next;
  logic signed [PW-1:0] demand_reg, demand_next, offset_reg, offset_next;
  logic [EW-1:0] err_reg, err_next, err_cause;
  logic [IW-1:0] irq_stat_reg, irq_stat_next, irq_en_reg, irq_en_next, irq_evt;
  logic irq_reg, irq_next, busy_reg, busy_next, idx_q_reg;
  logic [DW-1:0] rdata_reg, rdata_next;
  logic [15:0] div_cnt_reg, div_cnt_next;
  logic tick_reg, tick_next;

  logic home_active, idx_rise, wr_seq, seq_ok, sel_ok, start_ok, clear_ok;
  logic fwd_lim, rev_lim, hold, limit_hit, stop_done;
  logic signed [PW-1:0] measured, fe, fe_abs, vel, target;
  logic [4:0] sw_on;

  aosrch_home_sel u_home_sel (
    .clk(I_CLOCK),
    .arst_n(I_ARST_N),
    .sel(sel_reg[aosrch_pkg::SEL_W-1:0]),
    .unit_in(I_UNIT_IN),
    .drv_in(I_DRV_IN),
    .home_active(home_active)
  );

  aosrch_ramp u_ramp (
    .clk(I_CLOCK),
    .arst_n(I_ARST_N),
    .tick(tick_reg),
    .target(target),
    .rate($signed(ramp_reg)),
    .vel(vel)
  );

  // Servo update enable
  always_comb begin
    div_cnt_next = (div_cnt_reg == DIV_LAST) ? 16'h0000 : div_cnt_reg + 16'h0001;
    tick_next = (div_cnt_reg == DIV_LAST);
  end

  // Inputs are active low so a broken wire looks asserted
  always_comb begin
    sw_on = ~I_SWITCHES_N;
    hold = ~I_SWITCHES_N.feedhold_n;
    fwd_lim = ~I_SWITCHES_N.fwd_lim_n;
    rev_lim = ~I_SWITCHES_N.rev_lim_n;
    idx_rise = I_ENC_INDEX & ~idx_q_reg;
    measured = $signed(I_ENC_POS) + offset_reg;
    fe = demand_reg - measured;
    fe_abs = fe[PW-1] ? -fe : fe;
    wr_seq = I_BUS.wr && (I_BUS.addr == aosrch_pkg::REG_SEQ);
    seq_ok = I_BUS.wdata[7:0] <= aosrch_pkg::SEQ_MAX;
    sel_ok = sel_reg <= aosrch_pkg::SEL_MAX;
    clear_ok = wr_seq && (I_BUS.wdata[7:0] == aosrch_pkg::SEQ_CLEAR);
    start_ok = wr_seq && seq_ok && sel_ok && !clear_ok && (state_reg == aosrch_pkg::ST_IDLE);
    limit_hit = (dir_fwd_reg ? fwd_lim : rev_lim) &&
                (state_reg inside {aosrch_pkg::ST_FAST, aosrch_pkg::ST_CREEP_OFF,
                                   aosrch_pkg::ST_CREEP_Z});
    stop_done = (vel == '0);
  end

  // Target velocity: feedhold forces zero; else fast phase uses demand speed, both creep phases creep, other states zero
  always_comb begin
    target = '0;
    if (!hold) begin
      if (state_reg == aosrch_pkg::ST_FAST) begin
        target = dir_fwd_reg ? $signed(speed_reg) : -$signed(speed_reg);
      end else if (state_reg inside {aosrch_pkg::ST_CREEP_OFF, aosrch_pkg::ST_CREEP_Z}) begin
        target = dir_fwd_reg ? $signed(creep_reg) : -$signed(creep_reg);
      end
    end
  end

  // Search sequencer
  always_comb begin
    state_next = state_reg;
    seq_next = seq_reg;
    dir_fwd_next = dir_fwd_reg;
    case (state_reg)
      aosrch_pkg::ST_IDLE: begin
        if (start_ok) begin
          seq_next = I_BUS.wdata[7:0];
          case (I_BUS.wdata[7:0])
            aosrch_pkg::SEQ_Z_FWD: begin
              state_next = aosrch_pkg::ST_CREEP_Z;
              dir_fwd_next = 1'b1;
            end
            aosrch_pkg::SEQ_Z_REV: begin
              state_next = aosrch_pkg::ST_CREEP_Z;
              dir_fwd_next = 1'b0;
            end
            aosrch_pkg::SEQ_SW_FWD, aosrch_pkg::SEQ_SWZ_FWD: begin
              state_next = aosrch_pkg::ST_FAST;
              dir_fwd_next = 1'b1;
            end
            default: begin
              state_next = aosrch_pkg::ST_FAST;
              dir_fwd_next = 1'b0;
            end
          endcase
        end
      end
      aosrch_pkg::ST_FAST: begin
        if (limit_hit) begin
          state_next = aosrch_pkg::ST_STOP;
        end else if (home_active) begin
          state_next = aosrch_pkg::ST_CREEP_OFF;
          dir_fwd_next = !dir_fwd_reg;
        end
      end
      aosrch_pkg::ST_CREEP_OFF: begin
        if (limit_hit) begin
          state_next = aosrch_pkg::ST_STOP;
        end else if (!home_active) begin
          if (seq_reg == aosrch_pkg::SEQ_SWZ_FWD || seq_reg == aosrch_pkg::SEQ_SWZ_REV) begin
            state_next = aosrch_pkg::ST_CREEP_Z;
          end else begin
            state_next = aosrch_pkg::ST_ZERO;
          end
        end
      end
      aosrch_pkg::ST_CREEP_Z: begin
        if (limit_hit) begin
          state_next = aosrch_pkg::ST_STOP;
        end else if (idx_rise) begin
          state_next = aosrch_pkg::ST_ZERO;
        end
      end
      aosrch_pkg::ST_ZERO: begin
        state_next = aosrch_pkg::ST_STOP;
      end
      default: begin
        if (stop_done) begin
          state_next = aosrch_pkg::ST_IDLE;
        end
      end
    endcase
    busy_next = (state_next != aosrch_pkg::ST_IDLE);
  end

  // Demand position and measured offset; zeroing keeps the following error
  always_comb begin
    demand_next = demand_reg;
    offset_next = offset_reg;
    if (state_reg == aosrch_pkg::ST_ZERO) begin
      demand_next = '0;
      offset_next = offset_reg - demand_reg;
    end else if (clear_ok) begin
      demand_next = measured;
    end else if (tick_reg) begin
      demand_next = demand_reg + vel;
    end
  end

  // Error flags: a present cause re-sets a bit, so set wins over clear
  always_comb begin
    err_cause = '0;
    err_cause[aosrch_pkg::ERR_FE_WARN] = fe_abs > $signed(bound_reg >> 1);
    err_cause[aosrch_pkg::ERR_COMMS] = I_DRV_COMMS_ERR;
    err_cause[aosrch_pkg::ERR_DRIVE] = I_DRV_FAULT;
    err_cause[aosrch_pkg::ERR_FOLLOWING_ERROR_BOUND] = fe_abs > $signed(bound_reg);
    err_cause[aosrch_pkg::ERR_CANCEL] = limit_hit;
    err_next = err_reg;
    if (clear_ok) begin
      err_next = err_reg & ~aosrch_pkg::ERR_CLEAR_MASK;
    end
    err_next = err_next | err_cause;
  end

  // Interrupt status, clear and enable
  always_comb begin
    irq_evt = '0;
    irq_evt[aosrch_pkg::IRQ_DONE] = (state_reg == aosrch_pkg::ST_STOP) && stop_done;
    irq_evt[aosrch_pkg::IRQ_REJECT] = wr_seq && !clear_ok && !start_ok;
    irq_evt[aosrch_pkg::IRQ_CANCEL] = limit_hit;
    irq_stat_next = irq_stat_reg;
    if (I_BUS.wr && I_BUS.addr == aosrch_pkg::REG_IRQ_CLR) begin
      irq_stat_next = irq_stat_reg & ~I_BUS.wdata[IW-1:0];
    end
    irq_stat_next = irq_stat_next | irq_evt;
    irq_next = |(irq_stat_next & irq_en_next);
  end

  // Register writes; seq and clear offsets only trigger actions
  always_comb begin
    sel_next = sel_reg;
    creep_next = creep_reg;
    speed_next = speed_reg;
    ramp_next = ramp_reg;
    bound_next = bound_reg;
    irq_en_next = irq_en_reg;
    if (I_BUS.wr) begin
      if (I_BUS.addr == aosrch_pkg::REG_HOME_SEL) begin
        sel_next = I_BUS.wdata[7:0];
      end else if (I_BUS.addr == aosrch_pkg::REG_CREEP) begin
        creep_next = I_BUS.wdata;
      end else if (I_BUS.addr == aosrch_pkg::REG_SPEED) begin
        speed_next = I_BUS.wdata;
      end else if (I_BUS.addr == aosrch_pkg::REG_RAMP) begin
        ramp_next = I_BUS.wdata;
      end else if (I_BUS.addr == aosrch_pkg::REG_FE_BOUND) begin
        bound_next = I_BUS.wdata;
      end else if (I_BUS.addr == aosrch_pkg::REG_IRQ_EN) begin
        irq_en_next = I_BUS.wdata[IW-1:0];
      end
    end
  end

  // Read data valid only in the cycle after the strobe; unmapped reads zero
  always_comb begin
    rdata_next = '0;
    if (I_BUS.rd) begin
      if (I_BUS.addr == aosrch_pkg::REG_SEQ) begin
        rdata_next = {24'h000000, seq_reg};
      end else if (I_BUS.addr == aosrch_pkg::REG_HOME_SEL) begin
        rdata_next = {24'h000000, sel_reg};
      end else if (I_BUS.addr == aosrch_pkg::REG_CREEP) begin
        rdata_next = creep_reg;
      end else if (I_BUS.addr == aosrch_pkg::REG_SPEED) begin
        rdata_next = speed_reg;
      end else if (I_BUS.addr == aosrch_pkg::REG_RAMP) begin
        rdata_next = ramp_reg;
      end else if (I_BUS.addr == aosrch_pkg::REG_FE_BOUND) begin
        rdata_next = bound_reg;
      end else if (I_BUS.addr == aosrch_pkg::REG_STATUS) begin
        rdata_next = {16'h0000, 1'b0, home_active, sw_on, seq_reg, busy_reg};
      end else if (I_BUS.addr == aosrch_pkg::REG_DEMAND) begin
        rdata_next = demand_reg;
      end else if (I_BUS.addr == aosrch_pkg::REG_MEASURED) begin
        rdata_next = measured;
      end else if (I_BUS.addr == aosrch_pkg::REG_ERR_FLAGS) begin
        rdata_next = {20'h00000, err_reg};
      end else if (I_BUS.addr == aosrch_pkg::REG_IRQ_STAT) begin
        rdata_next = {29'h0000000, irq_stat_reg};
      end else if (I_BUS.addr == aosrch_pkg::REG_IRQ_EN) begin
        rdata_next = {29'h0000000, irq_en_reg};
      end
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_reg <= aosrch_pkg::ST_IDLE;
      seq_reg <= aosrch_pkg::SEQ_CLEAR;
      sel_reg <= aosrch_pkg::SEL_RST;
      dir_fwd_reg <= 1'b1;
      creep_reg <= aosrch_pkg::CREEP_RST;
      speed_reg <= aosrch_pkg::SPEED_RST;
      ramp_reg <= aosrch_pkg::RAMP_RST;
      bound_reg <= aosrch_pkg::FE_BOUND_RST;
      demand_reg <= '0;
      offset_reg <= '0;
      err_reg <= '0;
      irq_stat_reg <= '0;
      irq_en_reg <= '0;
      irq_reg <= 1'b0;
      busy_reg <= 1'b0;
      rdata_reg <= '0;
      idx_q_reg <= 1'b0;
      div_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      seq_reg <= seq_next;
      sel_reg <= sel_next;
      dir_fwd_reg <= dir_fwd_next;
      creep_reg <= creep_next;
      speed_reg <= speed_next;
      ramp_reg <= ramp_next;
      bound_reg <= bound_next;
      demand_reg <= demand_next;
      offset_reg <= offset_next;
      err_reg <= err_next;
      irq_stat_reg <= irq_stat_next;
      irq_en_reg <= irq_en_next;
      irq_reg <= irq_next;
      busy_reg <= busy_next;
      rdata_reg <= rdata_next;
      idx_q_reg <= I_ENC_INDEX;
      div_cnt_reg <= div_cnt_next;
      tick_reg <= tick_next;
    end
  end

  always_comb begin
    O_RDATA = rdata_reg;
    O_IRQ = irq_reg;
    O_BUSY = busy_reg;
    O_VEL_CMD = vel;
    O_DEMAND_POS = demand_reg;
  end

  chk_reject_bad_seq: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    (wr_seq && I_BUS.wdata[7:0] > aosrch_pkg::SEQ_MAX && state_reg == aosrch_pkg::ST_IDLE)
    |=> state_reg == aosrch_pkg::ST_IDLE && irq_stat_reg[aosrch_pkg::IRQ_REJECT])
    else $error("bad sequence number started motion");
  chk_reject_bad_sel: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    (wr_seq && sel_reg > aosrch_pkg::SEL_MAX && state_reg == aosrch_pkg::ST_IDLE)
    |=> state_reg == aosrch_pkg::ST_IDLE)
    else $error("bad selector started motion");
  chk_busy_follows: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    O_BUSY == (state_reg != aosrch_pkg::ST_IDLE))
    else $error("busy does not track the sequence");
  chk_zero_keeps_fe: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    state_reg == aosrch_pkg::ST_ZERO ##1 $stable(I_ENC_POS)
    |-> demand_reg == '0 && fe == $past(fe))
    else $error("zeroing lost the following error");
  chk_stop_after_zero: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    state_reg == aosrch_pkg::ST_ZERO |=> state_reg == aosrch_pkg::ST_STOP ##1
    state_reg != aosrch_pkg::ST_ZERO)
    else $error("no deceleration after zeroing");
  chk_seq0_copy: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    (clear_ok && state_reg != aosrch_pkg::ST_ZERO) |=> demand_reg == $past(measured))
    else $error("clear did not copy measured position");
  chk_seq0_clears: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    (clear_ok && err_cause == '0) |=> (err_reg & aosrch_pkg::ERR_CLEAR_MASK) == '0 &&
    state_reg == $past(state_reg))
    else $error("clear left flags set or moved the axis");
  chk_creep_speed: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    (state_reg == aosrch_pkg::ST_CREEP_Z && !hold)
    |-> (target == $signed(creep_reg) || target == -$signed(creep_reg)))
    else $error("index search not at creep speed");
  chk_limit_cancel: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    (limit_hit) |=> state_reg == aosrch_pkg::ST_STOP && err_reg[aosrch_pkg::ERR_CANCEL])
    else $error("limit did not cancel the search");
endmodule

/* File: aosrch_top_test.sv */
/*
  Testbench of the origin search block: reset values, all six searches,
  rejects, error clear and limit cancel.
  Assumes the drive model is compiled before it.
*/
`timescale 1ns/1ps
module aosrch_top_test;
  typedef struct {logic [7:0] a; logic [31:0] v;} aosrch_rrow_t;
  typedef struct {logic [7:0] seq; logic [7:0] sel; logic neg;} aosrch_srow_t;
  logic clk = 0;
  logic arst_n = 0;
  aosrch_pkg::aosrch_bus_t bus = '0;
  aosrch_pkg::aosrch_sw_t sw = '1;
  logic fault = 0;
  logic comms = 0;
  logic irq, busy, idx;
  logic [7:0] hsel = 8'h00;
  logic [15:0] unit_in, drv_in;
  logic [31:0] enc, rdata, vel, dem, d, d2;
  int errors = 0;
  int checks = 0;
  int cyc = 0;
  aosrch_rrow_t regs[6] = '{'{8'h08, 32'h10}, '{8'h0c, 32'h100}, '{8'h10, 32'h4},
    '{8'h14, 32'h1000}, '{8'h2c, 32'h0}, '{8'hfc, 32'h0}};
  aosrch_srow_t seqs[6] = '{'{8'h01, 8'h00, 0}, '{8'h02, 8'h00, 1}, '{8'h03, 8'h05, 1},
    '{8'h04, 8'h14, 0}, '{8'h05, 8'h1f, 1}, '{8'h06, 8'h10, 0}};
  aosrch_top #(.SERVO_DIV(4)) u_aosrch_top (.I_CLOCK(clk), .I_ARST_N(arst_n), .I_BUS(bus),
    .I_SWITCHES_N(sw), .I_UNIT_IN(unit_in), .I_DRV_IN(drv_in), .I_ENC_POS(enc),
    .I_ENC_INDEX(idx), .I_DRV_COMMS_ERR(comms), .I_DRV_FAULT(fault), .O_RDATA(rdata),
    .O_IRQ(irq), .O_BUSY(busy), .O_VEL_CMD(vel), .O_DEMAND_POS(dem));
  aosrch_drive_model u_aosrch_drive_model (.i_clk(clk), .i_arst_n(arst_n), .i_sel(hsel),
    .i_vel(vel), .o_enc_pos(enc), .o_index(idx), .o_unit_in(unit_in), .o_drv_in(drv_in));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Ceiling well above the longest search run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      errors++;
      finish_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk) begin
      bus.wr <= 1;
      bus.addr <= a;
      bus.wdata <= v;
    end
    @(posedge clk) bus.wr <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk) begin
      bus.rd <= 1;
      bus.addr <= a;
    end
    @(posedge clk) bus.rd <= 0;
    #1 v = rdata;
  endtask
  task automatic start(input logic [7:0] s, input logic b);
    wr(8'h00, {24'h0, s});
    repeat (2) @(posedge clk);
    #1 chk("busy", {31'b0, b}, {31'b0, busy});
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 20000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("idle", 0, {31'b0, busy});
  endtask
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1;
    foreach (regs[i]) begin
      rd(regs[i].a, d);
      chk("reg", regs[i].v, d);
    end
    $display("reset values done");
    wr(8'h30, 32'h1);
    foreach (seqs[i]) begin
      hsel <= seqs[i].sel;
      wr(8'h04, {24'h0, seqs[i].sel});
      start(seqs[i].seq, 1);
      wait_idle();
      chk("vel_rest", 0, vel);
      rd(8'h1c, d);
      chk("dem_sign", {31'b0, seqs[i].neg}, {31'b0, d[31]});
      chk("dem_near", 1, {31'b0, ($signed(d) < 256 && $signed(d) > -256)});
      chk("irq_on", 1, {31'b0, irq});
      wr(8'h2c, 32'h7);
      #1 chk("irq_off", 0, {31'b0, irq});
    end
    $display("searches done");
    wr(8'h04, 32'h20);
    start(8'h03, 0);
    wr(8'h04, 32'h0);
    start(8'h07, 0);
    rd(8'h28, d);
    chk("reject", 32'h2, d);
    wr(8'h2c, 32'h7);
    start(8'h01, 1);
    wr(8'h00, 32'h2);
    fault <= 1;
    comms <= 1;
    sw.fwd_lim_n <= 0;
    wait_idle();
    rd(8'h24, d);
    chk("flags", 32'h80c, d);
    rd(8'h28, d);
    chk("irq_bits", 32'h3, {30'b0, d[2:1]});
    sw.fwd_lim_n <= 1;
    // Fault and comms error still present, so the clear keeps their flags
    wr(8'h00, 32'h0);
    rd(8'h24, d);
    chk("flag_kept", 32'hc, d);
    fault <= 0;
    comms <= 0;
    wr(8'h00, 32'h0);
    rd(8'h24, d);
    chk("flag_clr", 32'h0, d);
    rd(8'h1c, d2);
    rd(8'h20, d);
    chk("dem_meas", d, d2);
    chk("dem_port", d, dem);
    // Feedhold alone asserted; last accepted sequence was 1, axis idle
    sw.feedhold_n <= 0;
    rd(8'h18, d);
    chk("status", 32'h2002, d);
    sw.feedhold_n <= 1;
    $display("errors and rejects done");
    finish_test();
  end
endmodule
